// *** core/erf_pkg.sv ***
// Behaviour
// R1: unicast passes on exact station address match
// R2: combine set means AND, clear means OR
// R3: control register all clear accepts everything
// R4: checksum over selected bytes of 64-byte window
// R5: pattern passes when checksum equals expected value
// R6: window starts at offset from destination address
// R7: each mask bit includes its window byte
// R8: masked-out bytes are skipped, not zeroed
// R9: window past frame end fails pattern test
// R10: checksum uses the dma ones-complement algorithm
// R11: host programs offset, mask, checksum before enabling
// R12: wake-up needs station match plus pattern in data
// R13: six 0xFF then sixteen address copies
// R14: crc of destination address indexes hash table
// R15: hash passes when selected table bit set
// R16: all-zero hash table always passes
// R17: multicast passes when first address lsb set
// R18: broadcast passes on all-ones destination address
// R19: control bits ordered unicast down to broadcast
// R20: crc check enable discards bad-crc frames
// R21: disabled tests take no part in decision
package erf_pkg;
   // ------------------------------------------------------------
   // register map (byte registers)
   // ------------------------------------------------------------
   localparam int NUM_REGS = 28;
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_STATION = 5'h01;
   localparam logic [4:0] ADDR_MASK = 5'h07;
   localparam logic [4:0] ADDR_CSUM_LO = 5'h0F;
   localparam logic [4:0] ADDR_CSUM_HI = 5'h10;
   localparam logic [4:0] ADDR_OFF_LO = 5'h11;
   localparam logic [4:0] ADDR_OFF_HI = 5'h12;
   localparam logic [4:0] ADDR_HASH = 5'h13;
   localparam logic [4:0] ADDR_STATUS = 5'h1B;
   localparam logic [7:0] CTRL_RESET = 8'hA1;
   // ------------------------------------------------------------
   // control bit positions
   // ------------------------------------------------------------
   localparam int BIT_UNICAST = 7;
   localparam int BIT_COMBINE = 6;
   localparam int BIT_CRC = 5;
   localparam int BIT_PATTERN = 4;
   localparam int BIT_WAKEUP = 3;
   localparam int BIT_HASH = 2;
   localparam int BIT_MULTICAST = 1;
   localparam int BIT_BROADCAST = 0;
   // ------------------------------------------------------------
   // frame geometry
   // ------------------------------------------------------------
   localparam int ADDR_BYTES = 6;
   localparam int DATA_START = 14;
   localparam int WINDOW_BYTES = 64;
   localparam int SYNC_BYTES = 6;
   localparam int ADDR_REPEATS = 16;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam int HASH_LSB = 23;
endpackage

// *** core/erf_filter.sv ***
module erf_filter
   import erf_pkg::*;
#(
   parameter int POS_W = 12
)
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // register access
   input wire logic CFG_WR,
   input wire logic [4:0] CFG_ADDR,
   input wire logic [7:0] CFG_WDATA,
   output logic [7:0] CFG_RDATA,
   // incoming frame bytes, crc bytes included
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_LAST,
   input wire logic RX_CRC_OK,
   // decision
   output logic FRAME_DONE,
   output logic FRAME_ACCEPT
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] regs_d [NUM_REGS];
   logic [7:0] rdata_d, rdata_q;
   logic [7:0] status_d, status_q;
   logic [7:0] ctrl;
   logic [47:0] station;
   logic [63:0] mask;
   logic [15:0] exp_csum;
   logic [15:0] win_off;
   logic [63:0] hash_tbl;

   assign ctrl = regs_q[ADDR_CTRL];
   assign exp_csum = {regs_q[ADDR_CSUM_HI], regs_q[ADDR_CSUM_LO]};
   assign win_off = {regs_q[ADDR_OFF_HI], regs_q[ADDR_OFF_LO]};

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_wide
         assign mask[g*8 +: 8] = regs_q[ADDR_MASK + g];
         assign hash_tbl[g*8 +: 8] = regs_q[ADDR_HASH + g];
         if (g < ADDR_BYTES)
         begin : g_sta
            // first address byte on the wire sits in the low byte
            assign station[g*8 +: 8] = regs_q[ADDR_STATION + g];
         end
      end
   endgenerate

   always_comb
   begin
      regs_d = regs_q;
      // status register is read-only; writes to it are dropped
      if (CFG_WR && CFG_ADDR < ADDR_STATUS)
         regs_d[CFG_ADDR] = CFG_WDATA;
      if (CFG_ADDR == ADDR_STATUS)
         rdata_d = status_q;
      else if (CFG_ADDR < ADDR_STATUS)
         rdata_d = regs_q[CFG_ADDR];
      else
         rdata_d = 8'h00;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            regs_q[i] <= 8'h00;
         regs_q[ADDR_CTRL] <= CTRL_RESET; // [R19]
         rdata_q <= 8'h00;
      end
      else
      begin
         regs_q <= regs_d;
         rdata_q <= rdata_d;
      end
   end

   assign CFG_RDATA = rdata_q;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0] b);
      logic [31:0] r;
      r = c;
      for (int k = 0; k < 8; k++)
         r = (r[0] ^ b[k]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction
   // ones-complement add with end-around carry, as the dma engine does
   function automatic logic [15:0] oc_add(input logic [15:0] a,
                                          input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction

   // ------------------------------------------------------------
   // frame tracking
   // ------------------------------------------------------------
   logic [POS_W-1:0] pos_d, pos_q;
   logic [47:0] da_d, da_q;
   logic [31:0] crc_d, crc_q;
   logic [15:0] sum_d, sum_q;
   logic [7:0] hold_d, hold_q;
   logic odd_d, odd_q;
   logic [2:0] ff_d, ff_q;
   logic [2:0] bidx_d, bidx_q;
   logic [4:0] rep_d, rep_q;
   logic magic_d, magic_q;
   logic end_d, end_q;
   logic crc_ok_d, crc_ok_q;
   logic done_d, done_q;
   logic acc_d, acc_q;
   logic [16:0] rel;
   logic in_win;
   logic [5:0] widx;

   always_comb
   begin
      rel = {{(17-POS_W){1'b0}}, pos_q} - {1'b0, win_off};
      in_win = (rel[16] == 1'b0) && (rel[15:0] < 16'(WINDOW_BYTES)); // [R6]
      widx = rel[5:0];
      pos_d = pos_q;
      da_d = da_q;
      crc_d = crc_q;
      sum_d = sum_q;
      hold_d = hold_q;
      odd_d = odd_q;
      ff_d = ff_q;
      bidx_d = bidx_q;
      rep_d = rep_q;
      magic_d = magic_q;
      end_d = 1'b0;
      crc_ok_d = crc_ok_q;
      if (RX_VALID)
      begin
         pos_d = pos_q + 1'b1;
         if (pos_q < POS_W'(ADDR_BYTES))
         begin
            da_d[pos_q[2:0]*8 +: 8] = RX_DATA;
            crc_d = crc_byte(crc_q, RX_DATA); // [R14]
         end
         // unselected bytes never touch the pairing state [R8]
         if (in_win && mask[widx]) // [R7]
         begin
            if (!odd_q)
            begin
               hold_d = RX_DATA;
               odd_d = 1'b1;
            end
            else
            begin
               sum_d = oc_add(sum_q, {hold_q, RX_DATA}); // [R4] [R10]
               odd_d = 1'b0;
            end
         end
         // sync run then sixteen copies; a mismatch restarts the hunt
         if (pos_q >= POS_W'(DATA_START) && !magic_q)
         begin
            if (ff_q == 3'(SYNC_BYTES) &&
                RX_DATA == station[bidx_q*8 +: 8]) // [R13]
            begin
               if (bidx_q == 3'(ADDR_BYTES - 1))
               begin
                  bidx_d = 3'h0;
                  rep_d = rep_q + 1'b1;
                  if (rep_q == 5'(ADDR_REPEATS - 1))
                     magic_d = 1'b1;
               end
               else
                  bidx_d = bidx_q + 1'b1;
            end
            else
            begin
               bidx_d = 3'h0;
               rep_d = 5'h00;
               if (RX_DATA == 8'hFF)
               begin
                  // stay synced while the run of ones continues
                  if (ff_q != 3'(SYNC_BYTES) || bidx_q != 3'h0 ||
                      rep_q != 5'h00)
                     ff_d = (ff_q == 3'(SYNC_BYTES) || bidx_q != 3'h0 ||
                             rep_q != 5'h00) ? 3'h1 : ff_q + 1'b1;
               end
               else
                  ff_d = 3'h0;
            end
         end
         if (RX_LAST)
         begin
            end_d = 1'b1;
            crc_ok_d = RX_CRC_OK;
         end
      end
      if (end_q)
      begin
         pos_d = '0;
         crc_d = 32'hFFFFFFFF;
         sum_d = 16'h0000;
         odd_d = 1'b0;
         ff_d = 3'h0;
         bidx_d = 3'h0;
         rep_d = 5'h00;
         magic_d = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // decision, one cycle after the last byte
   // ------------------------------------------------------------
   logic [15:0] sum_fin;
   logic [16:0] win_end;
   logic [5:0] pass, en;
   logic t_uni, t_pat, t_wake, t_hash, t_mc, t_bc;

   always_comb
   begin
      // a trailing odd byte pairs with a zero low byte
      sum_fin = odd_q ? oc_add(sum_q, {hold_q, 8'h00}) : sum_q;
      win_end = {1'b0, win_off} + 17'(WINDOW_BYTES);
      t_uni = (da_q == station); // [R1]
      t_pat = (~sum_fin == exp_csum) && // [R5]
              ({{(17-POS_W){1'b0}}, pos_q} >= win_end); // [R9]
      t_wake = t_uni && magic_q; // [R12]
      t_hash = (hash_tbl == 64'h0) || // [R16]
               hash_tbl[crc_q[HASH_LSB +: 6]]; // [R15]
      t_mc = da_q[0]; // [R17]
      t_bc = (da_q == {48{1'b1}}); // [R18]
      pass = {t_uni, t_pat, t_wake, t_hash, t_mc, t_bc};
      en = {ctrl[BIT_UNICAST], ctrl[BIT_PATTERN], ctrl[BIT_WAKEUP],
            ctrl[BIT_HASH], ctrl[BIT_MULTICAST], ctrl[BIT_BROADCAST]};
      if (en == 6'h00)
         acc_d = 1'b1; // [R3]
      else if (ctrl[BIT_COMBINE])
         acc_d = &(pass | ~en); // [R2] [R21]
      else
         acc_d = |(pass & en); // [R2] [R21]
      if (ctrl[BIT_CRC] && !crc_ok_q)
         acc_d = 1'b0; // [R20]
      if (!end_q)
         acc_d = acc_q;
      done_d = end_q;
      status_d = end_q ? {1'b0, acc_d, pass} : status_q;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         pos_q <= '0;
         da_q <= 48'h0;
         crc_q <= 32'hFFFFFFFF;
         sum_q <= 16'h0000;
         hold_q <= 8'h00;
         odd_q <= 1'b0;
         ff_q <= 3'h0;
         bidx_q <= 3'h0;
         rep_q <= 5'h00;
         magic_q <= 1'b0;
         end_q <= 1'b0;
         crc_ok_q <= 1'b0;
         done_q <= 1'b0;
         acc_q <= 1'b0;
         status_q <= 8'h00;
      end
      else
      begin
         pos_q <= pos_d;
         da_q <= da_d;
         crc_q <= crc_d;
         sum_q <= sum_d;
         hold_q <= hold_d;
         odd_q <= odd_d;
         ff_q <= ff_d;
         bidx_q <= bidx_d;
         rep_q <= rep_d;
         magic_q <= magic_d;
         end_q <= end_d;
         crc_ok_q <= crc_ok_d;
         done_q <= done_d;
         acc_q <= acc_d;
         status_q <= status_d;
      end
   end

   assign FRAME_DONE = done_q;
   assign FRAME_ACCEPT = acc_q;
endmodule

// *** verif/erf_filter_properties.sv ***
module erf_filter_props
   import erf_pkg::*;
#(
   parameter int POS_W = 12
)
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // register access
   input wire logic CFG_WR,
   input wire logic [4:0] CFG_ADDR,
   input wire logic [7:0] CFG_WDATA,
   input wire logic [7:0] CFG_RDATA,
   // frame side
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_LAST,
   input wire logic RX_CRC_OK,
   input wire logic FRAME_DONE,
   input wire logic FRAME_ACCEPT
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // control mirror, rebuilt from port writes
   // ----------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   always_comb ctrl_d = (CFG_WR && CFG_ADDR == ADDR_CTRL) ? CFG_WDATA : ctrl_q;
   always_ff @(posedge SYS_CLK) ctrl_q <= RESET_N ? ctrl_d : CTRL_RESET;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   sequence frame_end(c);
      RX_VALID && RX_LAST && c;
   endsequence
   chk_done_late: assert property (frame_end(1'b1) |-> ##2 FRAME_DONE)
      else $error("done not two cycles after last byte");
   chk_done_pulse: assert property (FRAME_DONE |=> !FRAME_DONE)
      else $error("done longer than one cycle");
   chk_accept_hold: assert property (!FRAME_DONE |-> $stable(FRAME_ACCEPT))
      else $error("accept changed without done");
   chk_open_accept: assert property (
      frame_end((ctrl_q & 8'hBF) == 8'h00) |-> ##2 FRAME_ACCEPT)
      else $error("frame dropped with no test enabled");
   chk_crc_gate: assert property (
      frame_end(ctrl_q[BIT_CRC] && !RX_CRC_OK) |-> ##2 !FRAME_ACCEPT)
      else $error("bad crc frame accepted");
   chk_ctrl_read: assert property (
      CFG_ADDR == ADDR_CTRL && !CFG_WR |=> CFG_RDATA == ctrl_q)
      else $error("control read back wrong");
   chk_unmapped_zero: assert property (
      CFG_ADDR > ADDR_STATUS |=> CFG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   chk_reset_quiet: assert property ($rose(RESET_N) |->
      CFG_RDATA == 8'h00 && !FRAME_DONE && !FRAME_ACCEPT)
      else $error("outputs not cleared by reset");
endmodule

// *** verif/erf_frame_src.sv ***
module erf_frame_src
(
   // clock
   input wire logic clk,
   // frame bytes towards the filter
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic rx_crc_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
      rx_crc_ok = 1'b0;
   end
   // ----------------------------------------
   // byte stream; idle data is inverted so a stale byte never looks valid
   // ----------------------------------------
   task automatic send(input logic [7:0] f[$], input logic ok,
      input logic [31:0] gap);
      for (int i = 0; i < f.size(); i++)
      begin
         @(negedge clk);
         if (gap[i % 32])
         begin
            rx_valid = 1'b0;
            rx_data = ~rx_data;
            @(negedge clk);
         end
         rx_valid = 1'b1;
         rx_data = f[i];
         rx_last = (i == f.size() - 1);
         rx_crc_ok = ok;
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_last = 1'b0;
      rx_data = ~rx_data;
   endtask
endmodule

// *** verif/tb_top.sv ***
module tb_top
   import erf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset_n, cfg_wr, rx_valid, rx_last, rx_crc_ok, ok;
   logic frame_done, frame_accept;
   logic [4:0] cfg_addr;
   logic [7:0] cfg_wdata, cfg_rdata, rx_data, ctl;
   logic [7:0] fr[$];
   logic [47:0] sta;
   logic [63:0] ht, pm;
   logic [15:0] cs;
   int seed = 32'h1B75;
   int miscompares = 0;
   int comparisons = 0;
   always #20 sys_clk = ~sys_clk;
   erf_filter #(.POS_W(12)) erf_filter_i(.SYS_CLK(sys_clk),
      .RESET_N(reset_n), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr),
      .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .RX_VALID(rx_valid),
      .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_CRC_OK(rx_crc_ok),
      .FRAME_DONE(frame_done), .FRAME_ACCEPT(frame_accept));
   erf_frame_src erf_frame_src_i(.clk(sys_clk), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_crc_ok(rx_crc_ok));
   // ----------------------------------------
   // reporting, bus tasks, reference
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected register at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic cmp_dec(input logic g, input logic e);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected decision at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge sys_clk);
      cfg_wr = 1'b0;
   endtask
   task automatic wr64(input logic [4:0] a, input logic [63:0] v);
      for (int k = 0; k < 8; k++)
         wr(a + 5'(k), v[8 * k +: 8]);
   endtask
   task automatic setc(input logic [7:0] v);
      wr(ADDR_CTRL, v);
      ctl = v;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      cfg_addr = a;
      @(negedge sys_clk);
      cmp_reg(cfg_rdata, e);
   endtask
   task automatic mkf(input logic [47:0] da, input int n);
      fr = {};
      for (int i = 0; i < n; i++)
         fr.push_back(i < 6 ? da[47 - 8 * i -: 8] : 8'($random(seed)));
   endtask
   function automatic logic [5:0] hidx(input logic [47:0] da);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < 48; i++)
         c = (c >> 1) ^ ((c[0] ^ da[40 - 8 * (i / 8) + i % 8]) ? CRC_POLY : 0);
      return c[HASH_LSB +: 6];
   endfunction
   function automatic logic [15:0] csum(input int off, input logic [63:0] m);
      logic [31:0] s;
      logic [15:0] w;
      logic h;
      s = 0;
      w = 0;
      h = 0;
      for (int k = 0; k < WINDOW_BYTES; k++)
         if (m[k])
         begin
            if (h) s = s + {w[15:8], fr[off + k]};
            else w = {fr[off + k], 8'h00};
            h = !h;
         end
      if (h) s = s + w;
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      return ~s[15:0];
   endfunction
   function automatic logic acc(input logic [7:0] c, input logic k,
      input logic [1:0] pw);
      logic [47:0] da;
      logic [5:0] p, e;
      da = {fr[0], fr[1], fr[2], fr[3], fr[4], fr[5]};
      p = {da == sta, pw, ht == 0 || ht[hidx(da)], da[40], &da};
      e = {c[BIT_UNICAST], c[4:0]};
      if (c[BIT_CRC] && !k) return 1'b0;
      if (e == 0) return 1'b1;
      return c[BIT_COMBINE] ? (p & e) == e : |(p & e);
   endfunction
   task automatic run(input logic k, input logic e);
      erf_frame_src_i.send(fr, k, $random(seed) & $random(seed));
      for (int n = 0; n < 4 && frame_done !== 1'b1; n++)
         @(negedge sys_clk);
      if (frame_done !== 1'b1)
      begin
         miscompares++;
         tally_and_finish();
      end
      else
      begin
         cmp_dec(frame_accept, e);
         $display("frame test of %0d bytes ended", fr.size());
      end
   endtask
   initial
   begin
      logic [7:0] tbl[9];
      logic [47:0] da;
      int off;
      tbl = '{8'h00, 8'h40, 8'h20, 8'hA1, 8'h04, 8'h02, 8'h01, 8'h80,
         8'hC3};
      sys_clk = 1'b0;
      reset_n = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = 5'h00;
      cfg_wdata = 8'h00;
      ht = 64'h0;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1'b1;
      rd(ADDR_CTRL, CTRL_RESET);
      wr(ADDR_STATUS, 8'hFF);
      rd(ADDR_STATUS, 8'h00);
      rd(5'h1F, 8'h00);
      sta = 48'({$random(seed), $random(seed)});
      for (int i = 0; i < 6; i++)
         wr(ADDR_STATION + 5'(i), sta[47 - 8 * i -: 8]);
      for (int i = 0; i < 60; i++)
      begin
         if (i == 30)
         begin
            ht = 64'h1 << hidx(sta);
            wr64(ADDR_HASH, ht);
         end
         setc(i < 9 ? tbl[i] : 8'($random(seed)) & 8'hE7);
         rd(ADDR_CTRL, ctl);
         case ($unsigned($random(seed)) % 5)
            0: da = sta;
            1: da = {6{8'hFF}};
            2: da = sta ^ (48'h1 << ($unsigned($random(seed)) % 48));
            3: da = {8'h01 | 8'($random(seed)), 40'($random(seed))};
            default: da = 48'($random(seed));
         endcase
         mkf(da, 20 + i);
         ok = 1'($random(seed));
         run(ok, acc(ctl, ok, '0));
      end
      off = $unsigned($random(seed)) % 8;
      wr(ADDR_OFF_LO, 8'(off));
      wr(ADDR_OFF_HI, 8'h00);
      for (int v = 0; v < 4; v++)
      begin
         mkf(sta, off + 63 + (v > 0));
         pm = v < 2 ? 64'h0 : {$random(seed), $random(seed)};
         wr64(ADDR_MASK, pm);
         cs = csum(off, pm);
         cs = cs ^ 16'(v == 3);
         wr(ADDR_CSUM_LO, cs[7:0]);
         wr(ADDR_CSUM_HI, cs[15:8]);
         setc(8'h10);
         run(1'b1, v == 1 || v == 2);
      end
      setc(8'h08);
      for (int v = 0; v < 3; v++)
      begin
         mkf(v == 2 ? sta ^ 48'h1 : sta, 20);
         repeat (6) fr.push_back(8'hFF);
         repeat (16 - (v == 1))
            for (int i = 0; i < 6; i++)
               fr.push_back(sta[47 - 8 * i -: 8]);
         repeat (4) fr.push_back(8'($random(seed)));
         run(1'b1, acc(ctl, 1'b1, {1'b0, v == 0}));
      end
      tally_and_finish();
   end
endmodule
bind erf_filter erf_filter_props #(.POS_W(POS_W)) erf_filter_props_i(
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CFG_WR(CFG_WR),
   .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
   .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST),
   .RX_CRC_OK(RX_CRC_OK), .FRAME_DONE(FRAME_DONE),
   .FRAME_ACCEPT(FRAME_ACCEPT));
